/* include/spat_consts.svh */
`ifndef SPAT_CONSTS_SVH
`define SPAT_CONSTS_SVH

// ----------------------------------------------------------------
// Field positions (bit 0 is the most significant bit, index 31)
// ----------------------------------------------------------------
`define SPAT_SBR_VALID   31
`define SPAT_SBR_LEVEL   30
`define SPAT_SBR_ALT     29
`define SPAT_SBR_IO      28
`define SPAT_PTE_VALID   31
`define SPAT_PTE_RES     30
`define SPAT_PTE_READ    29
`define SPAT_PTE_WRITE   28
`define SPAT_PTE_EXEC    27
`define SPAT_FRAME_MSB   20
`define SPAT_FRAME_LSB   0
`define SPAT_LA_SEG_MSB  30
`define SPAT_LA_SEG_LSB  28
`define SPAT_LA_L2_MSB   27
`define SPAT_LA_L2_LSB   19
`define SPAT_LA_L1_MSB   18
`define SPAT_LA_L1_LSB   10
`define SPAT_LA_OFS_MSB  9
`define SPAT_LA_OFS_LSB  0

// ----------------------------------------------------------------
// Reset values, steps and fault codes
// ----------------------------------------------------------------
`define SPAT_SBR_RESET   32'h0000_0000
`define SPAT_DWORD_STEP  31'h0000_0002
`define SPAT_SBR_COUNT   8
`define SPAT_FC_READ     32'h0000_0000
`define SPAT_FC_WRITE    32'h0000_0001
`define SPAT_FC_EXEC     32'h0000_0002
`define SPAT_FC_SEG      32'h0000_0003
`define SPAT_FC_RANGE    32'h0000_0004
`define SPAT_FC_PTE      32'h0000_0005
`define SPAT_FC_IO       32'h0000_0006
`define SPAT_FC_PRIV     32'h0000_0007
`define SPAT_FC_NONE     32'h0000_0000

`endif

/* include/spat_pkg.sv */
`default_nettype none
package spat_pkg;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		SPAT_OP_READ, SPAT_OP_WRITE, SPAT_OP_FETCH,
		SPAT_OP_OPC011, SPAT_OP_PRIV, SPAT_OP_LOAD
	} spat_op_e;

	typedef enum logic [1:0] {
		SPAT_F_NONE, SPAT_F_PROT, SPAT_F_PAGE
	} spat_fault_e;

	typedef enum logic [2:0] {
		SPAT_ST_IDLE, SPAT_ST_WALK1, SPAT_ST_WALK2, SPAT_ST_LOAD
	} spat_state_e;

	typedef struct packed {
		spat_state_e      st;
		logic [7:0][31:0] segment_translation_base;
		logic [31:0]      sbr_rd;
		logic             mem_req;
		logic [30:0]      mem_addr;
		spat_op_e         op;
		logic [31:0]      la;
		logic [2:0]       ld_idx;
		logic [3:0]       ld_left;
		logic             rsp_valid;
		spat_fault_e      rsp_fault;
		logic [31:0]      rsp_code;
		logic [30:0]      rsp_paddr;
		logic             rsp_alt;
		logic             rsp_io;
	} spat_state_s;

endpackage
`default_nettype wire

/* include/spat_chk_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface spat_chk_if;
	logic [31:0]          pte;
	logic                 final_lvl;
	spat_pkg::spat_op_e    op;
	spat_pkg::spat_fault_e fault;
	logic [31:0]          code;

	modport chk  (input pte, final_lvl, op, output fault, code);
	modport user (output pte, final_lvl, op, input fault, code);
endinterface
`default_nettype wire

/* hdl/spat_pte_check.sv */
`timescale 1ns/1ps
`default_nettype none
`include "spat_consts.svh"
module spat_pte_check (
	spat_chk_if.chk c
);
	logic acc_ok;
	logic [31:0] acc_code;

	// ------------------------------------------------------------
	// Access bit selection by request kind
	// ------------------------------------------------------------
	always_comb begin
		acc_ok = 1'b1;
		acc_code = `SPAT_FC_NONE;
		case (c.op)
			spat_pkg::SPAT_OP_READ: begin
				acc_ok = c.pte[`SPAT_PTE_READ];
				acc_code = `SPAT_FC_READ;
			end
			spat_pkg::SPAT_OP_WRITE: begin
				acc_ok = c.pte[`SPAT_PTE_WRITE];
				acc_code = `SPAT_FC_WRITE;
			end
			spat_pkg::SPAT_OP_FETCH: begin
				acc_ok = c.pte[`SPAT_PTE_EXEC];
				acc_code = `SPAT_FC_EXEC;
			end
			default: begin
				acc_ok = 1'b1;
				acc_code = `SPAT_FC_NONE;
			end
		endcase
	end

	// ------------------------------------------------------------
	// Validity, then access, then residency
	// ------------------------------------------------------------
	always_comb begin
		c.fault = spat_pkg::SPAT_F_NONE;
		c.code = `SPAT_FC_NONE;
		if (!c.pte[`SPAT_PTE_VALID]) begin
			c.fault = spat_pkg::SPAT_F_PROT;
			c.code = `SPAT_FC_PTE;
		end else if (c.final_lvl && !acc_ok) begin
			c.fault = spat_pkg::SPAT_F_PROT;
			c.code = acc_code;
		end else if (!c.pte[`SPAT_PTE_RES]) begin
			c.fault = spat_pkg::SPAT_F_PAGE;
			c.code = `SPAT_FC_NONE;
		end
	end
endmodule
`default_nettype wire

/* hdl/spat_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "spat_consts.svh"
// Contract
// - Eight segment base registers, chosen by segment field
// - Invalid segment gives protection violation
// - Range checked only after segment is valid
// - Base bit 1 selects one or two levels
// - One level 1 Mbyte, two levels up to 512
// - One level needs address bits 4-12 zero
// - Opcodes 011 decode by base bit 2
// - I/O needs base bit 3, else violation
// - Base bits 11-31 give root pagetable frame
// - Frame is page address shifted right ten
// - Invalid pagetable entry gives protection violation
// - Access checked only after page is valid
// - Read denied by entry bit 2 clear
// - Write denied by entry bit 3 clear
// - Fetch denied by entry bit 4 clear
// - Non-resident page suspends with page fault
// - First level entry names next table, no access
// - Privileged work outside segment 0 is violation
// - Block load of base registers from memory
// - Address fields: segment, level 2, level 1, offset
// - Access fault codes 0, 1, 2
module spat_top (
	input  wire logic                  REF_CLK,
	input  wire logic                  RESET_N,
	input  wire logic                  REQ_VALID,
	output logic                       REQ_READY,
	input  wire spat_pkg::spat_op_e    REQ_OP,
	input  wire logic [31:0]           REQ_ADDR,
	input  wire logic [2:0]            REQ_SEG,
	input  wire logic [2:0]            REQ_FIRST,
	input  wire logic [3:0]            REQ_COUNT,
	output logic                       RSP_VALID,
	output spat_pkg::spat_fault_e      RSP_FAULT,
	output logic [31:0]                RSP_CODE,
	output logic [30:0]                RSP_PADDR,
	output logic                       RSP_ALT,
	output logic                       RSP_IO,
	output logic                       MEM_REQ,
	output logic [30:0]                MEM_ADDR,
	input  wire logic                  MEM_ACK,
	input  wire logic [31:0]           MEM_RDATA,
	input  wire logic [2:0]            SBR_SEL,
	output logic [31:0]                SBR_DATA
);
	spat_pkg::spat_state_s r_reg;
	spat_pkg::spat_state_s r_next;
	spat_chk_if            chk ();
	logic [31:0]           sel_sbr;
	logic [2:0]            la_seg;
	logic [8:0]            la_l2;
	logic [8:0]            la_l1;
	logic [9:0]            la_ofs;
	logic [8:0]            lr_l1;
	logic [9:0]            lr_ofs;
	logic [20:0]           pte_frame;

	// ------------------------------------------------------------
	// Entry checker
	// ------------------------------------------------------------

	// Entry under test is always the word just returned
	spat_pte_check u_check (
		.c (chk)
	);

	assign chk.pte = MEM_RDATA;
	assign chk.op = r_reg.op;
	assign chk.final_lvl = (r_reg.st == spat_pkg::SPAT_ST_WALK2);

	// ------------------------------------------------------------
	// Address field split
	// ------------------------------------------------------------

	// Fields of the incoming and latched logical address
	assign la_seg = REQ_ADDR[`SPAT_LA_SEG_MSB:`SPAT_LA_SEG_LSB];
	assign la_l2 = REQ_ADDR[`SPAT_LA_L2_MSB:`SPAT_LA_L2_LSB];
	assign la_l1 = REQ_ADDR[`SPAT_LA_L1_MSB:`SPAT_LA_L1_LSB];
	assign la_ofs = REQ_ADDR[`SPAT_LA_OFS_MSB:`SPAT_LA_OFS_LSB];
	assign lr_l1 = r_reg.la[`SPAT_LA_L1_MSB:`SPAT_LA_L1_LSB];
	assign lr_ofs = r_reg.la[`SPAT_LA_OFS_MSB:`SPAT_LA_OFS_LSB];

	// Base register of the addressed segment
	assign sel_sbr = r_reg.segment_translation_base[la_seg];

	// Frame of the returned entry; a page is frame plus ten zero bits
	assign pte_frame = MEM_RDATA[`SPAT_FRAME_MSB:`SPAT_FRAME_LSB];

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------

	// Handshake is combinational, data comes from flops
	assign REQ_READY = (r_reg.st == spat_pkg::SPAT_ST_IDLE);
	assign RSP_VALID = r_reg.rsp_valid;
	assign RSP_FAULT = r_reg.rsp_fault;
	assign RSP_CODE = r_reg.rsp_code;
	assign RSP_PADDR = r_reg.rsp_paddr;
	assign RSP_ALT = r_reg.rsp_alt;
	assign RSP_IO = r_reg.rsp_io;
	assign MEM_REQ = r_reg.mem_req;
	assign MEM_ADDR = r_reg.mem_addr;
	assign SBR_DATA = r_reg.sbr_rd;

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------

	// Sequencer: decode, walk, block load
	always_comb begin
		r_next = r_reg;
		r_next.rsp_valid = 1'b0;
		r_next.sbr_rd = r_reg.segment_translation_base[SBR_SEL];
		case (r_reg.st)
			spat_pkg::SPAT_ST_IDLE: begin
				if (REQ_VALID) begin
					r_next.op = REQ_OP;
					r_next.la = REQ_ADDR;
					r_next.rsp_fault = spat_pkg::SPAT_F_NONE;
					r_next.rsp_code = `SPAT_FC_NONE;
					r_next.rsp_paddr = '0;
					r_next.rsp_alt = 1'b0;
					r_next.rsp_io = 1'b0;
					case (REQ_OP)
						spat_pkg::SPAT_OP_READ,
						spat_pkg::SPAT_OP_WRITE,
						spat_pkg::SPAT_OP_FETCH: begin
							if (!sel_sbr[`SPAT_SBR_VALID]) begin
								// Segment closed
								r_next.rsp_valid = 1'b1;
								r_next.rsp_fault = spat_pkg::SPAT_F_PROT;
								r_next.rsp_code = `SPAT_FC_SEG;
							end else if (!sel_sbr[`SPAT_SBR_LEVEL] && la_l2 != 9'h000) begin
								// One level reaches 1 Mbyte only
								r_next.rsp_valid = 1'b1;
								r_next.rsp_fault = spat_pkg::SPAT_F_PROT;
								r_next.rsp_code = `SPAT_FC_RANGE;
							end else if (sel_sbr[`SPAT_SBR_LEVEL]) begin
								// Two levels: root indexed by level 2 field
								r_next.mem_req = 1'b1;
								r_next.mem_addr = {sel_sbr[`SPAT_FRAME_MSB:`SPAT_FRAME_LSB],
									la_l2, 1'b0};
								r_next.st = spat_pkg::SPAT_ST_WALK1;
							end else begin
								// One level: root indexed by level 1 field
								r_next.mem_req = 1'b1;
								r_next.mem_addr = {sel_sbr[`SPAT_FRAME_MSB:`SPAT_FRAME_LSB],
									la_l1, 1'b0};
								r_next.st = spat_pkg::SPAT_ST_WALK2;
							end
						end
						spat_pkg::SPAT_OP_OPC011: begin
							r_next.rsp_valid = 1'b1;
							if (r_reg.segment_translation_base[REQ_SEG][`SPAT_SBR_ALT]) begin
								r_next.rsp_alt = 1'b1;
							end else if (r_reg.segment_translation_base[REQ_SEG][`SPAT_SBR_IO]) begin
								r_next.rsp_io = 1'b1;
							end else begin
								r_next.rsp_fault = spat_pkg::SPAT_F_PROT;
								r_next.rsp_code = `SPAT_FC_IO;
							end
						end
						spat_pkg::SPAT_OP_PRIV: begin
							r_next.rsp_valid = 1'b1;
							if (REQ_SEG != 3'h0) begin
								r_next.rsp_fault = spat_pkg::SPAT_F_PROT;
								r_next.rsp_code = `SPAT_FC_PRIV;
							end
						end
						spat_pkg::SPAT_OP_LOAD: begin
							if (REQ_SEG != 3'h0) begin
								// Block load is privileged
								r_next.rsp_valid = 1'b1;
								r_next.rsp_fault = spat_pkg::SPAT_F_PROT;
								r_next.rsp_code = `SPAT_FC_PRIV;
							end else if (REQ_COUNT == 4'h0) begin
								r_next.rsp_valid = 1'b1;
							end else begin
								// Fetch consecutive doublewords
								r_next.mem_req = 1'b1;
								r_next.mem_addr = REQ_ADDR[30:0];
								r_next.ld_idx = REQ_FIRST;
								r_next.ld_left = REQ_COUNT;
								r_next.st = spat_pkg::SPAT_ST_LOAD;
							end
						end
						default: begin
							r_next.rsp_valid = 1'b1;
							r_next.rsp_fault = spat_pkg::SPAT_F_PROT;
							r_next.rsp_code = `SPAT_FC_PRIV;
						end
					endcase
				end
			end
			spat_pkg::SPAT_ST_WALK1: begin
				if (MEM_ACK) begin
					if (chk.fault != spat_pkg::SPAT_F_NONE) begin
						// Bad or absent second table
						r_next.mem_req = 1'b0;
						r_next.rsp_valid = 1'b1;
						r_next.rsp_fault = chk.fault;
						r_next.rsp_code = chk.code;
						r_next.st = spat_pkg::SPAT_ST_IDLE;
					end else begin
						// Entry frame holds the last-level table
						r_next.mem_addr = {pte_frame, lr_l1, 1'b0};
						r_next.st = spat_pkg::SPAT_ST_WALK2;
					end
				end
			end
			spat_pkg::SPAT_ST_WALK2: begin
				if (MEM_ACK) begin
					r_next.mem_req = 1'b0;
					r_next.rsp_valid = 1'b1;
					r_next.st = spat_pkg::SPAT_ST_IDLE;
					if (chk.fault != spat_pkg::SPAT_F_NONE) begin
						r_next.rsp_fault = chk.fault;
						r_next.rsp_code = chk.code;
					end else begin
						r_next.rsp_paddr = {pte_frame, lr_ofs};
					end
				end
			end
			spat_pkg::SPAT_ST_LOAD: begin
				if (MEM_ACK) begin
					// Store one base register, move to the next doubleword
					r_next.segment_translation_base[r_reg.ld_idx] = MEM_RDATA;
					r_next.ld_idx = r_reg.ld_idx + 3'h1;
					r_next.ld_left = r_reg.ld_left - 4'h1;
					r_next.mem_addr = r_reg.mem_addr + `SPAT_DWORD_STEP;
					if (r_reg.ld_left == 4'h1) begin
						r_next.mem_req = 1'b0;
						r_next.rsp_valid = 1'b1;
						r_next.st = spat_pkg::SPAT_ST_IDLE;
					end
				end
			end
			default: begin
				r_next.mem_req = 1'b0;
				r_next.st = spat_pkg::SPAT_ST_IDLE;
			end
		endcase
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------

	// All state in one struct, cleared on reset
	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end
endmodule
`default_nettype wire

/* test/spat_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module spat_monitor (
	input wire logic                  REF_CLK,
	input wire logic                  RESET_N,
	input wire logic                  REQ_VALID,
	input wire logic                  REQ_READY,
	input wire spat_pkg::spat_op_e    REQ_OP,
	input wire logic [31:0]           REQ_ADDR,
	input wire logic [2:0]            REQ_SEG,
	input wire logic                  RSP_VALID,
	input wire spat_pkg::spat_fault_e RSP_FAULT,
	input wire logic [31:0]           RSP_CODE,
	input wire logic [30:0]           RSP_PADDR,
	input wire logic                  RSP_ALT,
	input wire logic                  RSP_IO,
	input wire logic                  MEM_REQ,
	input wire logic [30:0]           MEM_ADDR,
	input wire logic                  MEM_ACK,
	input wire logic [31:0]           MEM_RDATA
);
	// ------------------------------------------------------------
	// Request and read data capture
	// ------------------------------------------------------------
	logic               take;
	logic               mop;
	spat_pkg::spat_op_e op_reg;
	logic [31:0]        la_reg;
	logic [31:0]        rd_reg;
	assign take = REQ_VALID && REQ_READY;
	assign mop  = op_reg inside {spat_pkg::SPAT_OP_READ, spat_pkg::SPAT_OP_WRITE, spat_pkg::SPAT_OP_FETCH};
	// Keep the taken request and the last read word
	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			op_reg <= spat_pkg::SPAT_OP_READ;
			la_reg <= 32'h0;
			rd_reg <= 32'h0;
		end else begin
			if (take) op_reg <= REQ_OP;
			if (take) la_reg <= REQ_ADDR;
			if (MEM_ACK) rd_reg <= MEM_RDATA;
		end
	end
	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!RESET_N);
	sequence s_take_mem;
		take && REQ_OP inside {spat_pkg::SPAT_OP_READ, spat_pkg::SPAT_OP_WRITE, spat_pkg::SPAT_OP_FETCH};
	endsequence
	sequence s_last_ack;
		MEM_REQ && MEM_ACK ##1 RSP_VALID && RSP_FAULT == spat_pkg::SPAT_F_NONE && mop;
	endsequence
	chk_priv_seg: assert property (take && REQ_OP inside {spat_pkg::SPAT_OP_PRIV, spat_pkg::SPAT_OP_LOAD}
		&& REQ_SEG != 3'h0 |=> RSP_VALID && RSP_FAULT == spat_pkg::SPAT_F_PROT && RSP_CODE == 32'h7)
		else $error("privileged work outside segment zero not refused");
	chk_opc_answer: assert property (take && REQ_OP == spat_pkg::SPAT_OP_OPC011
		|=> RSP_VALID && !(RSP_ALT && RSP_IO)) else $error("opcode 011 answer wrong");
	chk_opc_fault: assert property (RSP_VALID && op_reg == spat_pkg::SPAT_OP_OPC011
		|-> (RSP_FAULT == spat_pkg::SPAT_F_NONE) == (RSP_ALT || RSP_IO)) else $error("I/O gate wrong");
	chk_mem_hold: assert property (MEM_REQ && !MEM_ACK |=> MEM_REQ && $stable(MEM_ADDR))
		else $error("memory read dropped before ack");
	chk_root_index: assert property (s_take_mem |=> !MEM_REQ || (!MEM_ADDR[0]
		&& (MEM_ADDR[9:1] == la_reg[18:10] || MEM_ADDR[9:1] == la_reg[27:19])))
		else $error("table index wrong");
	chk_final_addr: assert property (s_last_ack |-> RSP_PADDR == {rd_reg[20:0], la_reg[9:0]})
		else $error("physical address wrong");
	chk_access_code: assert property (RSP_VALID && RSP_FAULT == spat_pkg::SPAT_F_PROT && mop
		&& RSP_CODE < 32'h3 |-> RSP_CODE == {29'h0, op_reg}) else $error("access code wrong");
	chk_page_fault: assert property (RSP_VALID && RSP_FAULT == spat_pkg::SPAT_F_PAGE
		|-> RSP_CODE == 32'h0 && RSP_PADDR == 31'h0 && mop) else $error("page fault answer wrong");
	chk_walk_end: assert property (RSP_VALID |-> !MEM_REQ) else $error("read left open");
	chk_walk_busy: assert property (MEM_REQ |-> !REQ_READY) else $error("ready during walk");
endmodule
bind spat_top spat_monitor u_mon (.REF_CLK, .RESET_N, .REQ_VALID, .REQ_READY, .REQ_OP, .REQ_ADDR,
	.REQ_SEG, .RSP_VALID, .RSP_FAULT, .RSP_CODE, .RSP_PADDR, .RSP_ALT, .RSP_IO, .MEM_REQ, .MEM_ADDR,
	.MEM_ACK, .MEM_RDATA);
`default_nettype wire

/* test/spat_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
module spat_mem_model (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        mem_req,
	input  wire logic [30:0] mem_addr,
	output logic             mem_ack,
	output logic [31:0]      mem_rdata
);
	logic [31:0] mem [logic [30:0]];
	int          lat = 0;
	int          cnt;
	// Answer each read after lat waits; released data line shows the inverse
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mem_ack <= 1'b0;
			cnt <= 0;
			mem_rdata <= 32'h0;
		end else if (mem_ack) begin
			mem_ack <= 1'b0;
			cnt <= 0;
			mem_rdata <= ~mem_rdata;
		end else if (mem_req && cnt >= lat) begin
			mem_ack <= 1'b1;
			mem_rdata <= mem.exists(mem_addr) ? mem[mem_addr] : 32'h0;
		end else if (mem_req) begin
			cnt <= cnt + 1;
		end
	end
endmodule
`default_nettype wire

/* test/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
	typedef struct {
		spat_pkg::spat_fault_e f;
		logic [31:0]           c;
		logic [30:0]           p;
		logic [1:0]            k;
	} spat_note_s;
	logic                  REF_CLK = 1'b0;
	logic                  RESET_N = 1'b0;
	logic                  REQ_VALID = 1'b0;
	spat_pkg::spat_op_e    REQ_OP = spat_pkg::SPAT_OP_READ;
	logic [31:0]           REQ_ADDR = 32'h0;
	logic [2:0]            REQ_SEG = 3'h0;
	logic [2:0]            REQ_FIRST = 3'h5;
	logic [3:0]            REQ_COUNT = 4'h8;
	logic [2:0]            SBR_SEL = 3'h0;
	logic                  REQ_READY, RSP_VALID, RSP_ALT, RSP_IO, MEM_REQ, MEM_ACK;
	spat_pkg::spat_fault_e RSP_FAULT;
	logic [31:0]           RSP_CODE, MEM_RDATA, SBR_DATA;
	logic [30:0]           RSP_PADDR, MEM_ADDR;
	spat_note_s            q [$];
	int                    fails = 0;
	int                    cmp_count = 0;
	logic [31:0]           sb [8];
	logic [20:0]           pf;
	logic [9:0]            ofs;
	spat_top DUT (.REF_CLK, .RESET_N, .REQ_VALID, .REQ_READY, .REQ_OP, .REQ_ADDR, .REQ_SEG, .REQ_FIRST,
		.REQ_COUNT, .RSP_VALID, .RSP_FAULT, .RSP_CODE, .RSP_PADDR, .RSP_ALT, .RSP_IO, .MEM_REQ, .MEM_ADDR,
		.MEM_ACK, .MEM_RDATA, .SBR_SEL, .SBR_DATA);
	spat_mem_model MEM (.clk(REF_CLK), .rst_n(RESET_N), .mem_req(MEM_REQ), .mem_addr(MEM_ADDR),
		.mem_ack(MEM_ACK), .mem_rdata(MEM_RDATA));
	always #5 REF_CLK = ~REF_CLK;
	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [31:0] la(logic [2:0] s, logic [8:0] a, logic [8:0] b, logic [9:0] o);
		return {1'b0, s, a, b, o};
	endfunction
	function automatic logic [31:0] ent(logic [4:0] fl, logic [20:0] fr);
		return {fl, 6'h0, fr};
	endfunction
	function automatic logic [30:0] ea(logic [20:0] fr, logic [8:0] i);
		return {fr, i, 1'b0};
	endfunction
	task automatic final_report;
		if (fails == 0 && cmp_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic tick;
		@(posedge REF_CLK);
		#1;
	endtask
	task automatic req(input spat_pkg::spat_op_e o, input logic [31:0] a, input logic [2:0] s,
		input spat_pkg::spat_fault_e f, input logic [31:0] c, input logic [30:0] p, input logic [1:0] k);
		int n;
		REQ_OP = o;
		REQ_ADDR = a;
		REQ_SEG = s;
		REQ_VALID = 1'b1;
		MEM.lat = $urandom % 4;
		for (n = 0; n < 300 && REQ_READY !== 1'b1; n++) tick;
		if (n == 300) fails++;
		if (n == 300) final_report;
		@(posedge REF_CLK);
		q.push_back('{f, c, p, k});
		#1;
		REQ_VALID = 1'b0;
		// Let one edge pass so a following request never re-raises valid in this time step
		tick;
	endtask
	task automatic drain;
		for (int n = 0; n < 300 && q.size() > 0; n++) tick;
		if (q.size() > 0) fails++;
		if (q.size() > 0) final_report;
		tick;
	endtask
	task automatic rdback(input bit z);
		for (int i = 0; i < 8; i++) begin
			SBR_SEL = 3'(i);
			tick;
			chk("sbr", SBR_DATA, z ? 32'h0 : sb[i]);
		end
	endtask
	// Compare each answer with the oldest note
	always @(negedge REF_CLK) begin
		spat_note_s e;
		if (RSP_VALID === 1'b1 && q.size() == 0) chk("rsp_unexpected", 32'h1, 32'h0);
		if (RSP_VALID === 1'b1 && q.size() > 0) begin
			e = q.pop_front();
			chk("fault", 32'(RSP_FAULT), 32'(e.f));
			if (e.f != spat_pkg::SPAT_F_NONE) chk("code", RSP_CODE, e.c);
			if (e.k == 2'h1) chk("paddr", {1'b0, RSP_PADDR}, {1'b0, e.p});
			if (e.k == 2'h2) chk("alt_io", {30'h0, RSP_ALT, RSP_IO}, {30'h0, e.p[1:0]});
		end
	end
	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		void'($urandom(88));
		pf = 21'($urandom);
		sb[0] = {4'hA, 7'h0, 21'h00010};
		sb[1] = 32'h0;
		sb[2] = {4'h9, 7'h0, 21'h00012};
		sb[3] = {4'h8, 7'h0, 21'h00013};
		sb[4] = {4'hC, 7'h0, 21'h00014};
		for (int i = 5; i < 8; i++) sb[i] = $urandom & 32'h0FFF_FFFF;
		for (int k = 0; k < 8; k++) MEM.mem[31'h100 + 31'(2 * k)] = sb[(k + 5) % 8];
		// Read only, write and execute without read, not resident, denied and absent
		MEM.mem[ea(21'h12, 9'h1)] = ent(5'h1C, pf);
		MEM.mem[ea(21'h12, 9'h4)] = ent(5'h1B, pf);
		MEM.mem[ea(21'h12, 9'h3)] = ent(5'h14, pf);
		MEM.mem[ea(21'h12, 9'h5)] = ent(5'h10, pf);
		MEM.mem[ea(21'h14, 9'h7)] = ent(5'h18, 21'h00015);
		MEM.mem[ea(21'h15, 9'h1)] = ent(5'h1C, pf);
		repeat (20) @(posedge REF_CLK);
		#1;
		RESET_N = 1'b1;
		rdback(1'b1);
		req(spat_pkg::SPAT_OP_READ, la(2, 0, 1, 0), 0, spat_pkg::SPAT_F_PROT, 32'h3, 0, 1);
		req(spat_pkg::SPAT_OP_LOAD, 32'h100, 3, spat_pkg::SPAT_F_PROT, 32'h7, 0, 0);
		req(spat_pkg::SPAT_OP_LOAD, 32'h100, 0, spat_pkg::SPAT_F_NONE, 0, 0, 0);
		drain;
		rdback(1'b0);
		REQ_COUNT = 4'h0;
		req(spat_pkg::SPAT_OP_LOAD, 32'h200, 0, spat_pkg::SPAT_F_NONE, 0, 0, 0);
		req(spat_pkg::SPAT_OP_PRIV, 0, 2, spat_pkg::SPAT_F_PROT, 32'h7, 0, 0);
		req(spat_pkg::SPAT_OP_PRIV, 0, 0, spat_pkg::SPAT_F_NONE, 0, 0, 0);
		req(spat_pkg::SPAT_OP_OPC011, 0, 0, spat_pkg::SPAT_F_NONE, 0, 2, 2);
		req(spat_pkg::SPAT_OP_OPC011, 0, 2, spat_pkg::SPAT_F_NONE, 0, 1, 2);
		req(spat_pkg::SPAT_OP_OPC011, 0, 3, spat_pkg::SPAT_F_PROT, 32'h6, 0, 2);
		req(spat_pkg::SPAT_OP_READ, la(1, 5, 0, 0), 0, spat_pkg::SPAT_F_PROT, 32'h3, 0, 1);
		req(spat_pkg::SPAT_OP_READ, la(2, 5, 1, 0), 0, spat_pkg::SPAT_F_PROT, 32'h4, 0, 1);
		// Every access kind against a read-only page and a page without read
		for (int o = 0; o < 3; o++) begin
			for (int g = 1; g < 5; g += 3) begin
				ofs = 10'($urandom);
				if ((g == 1) == (o == 0)) req(spat_pkg::spat_op_e'(o), la(2, 0, 9'(g), ofs), 0,
					spat_pkg::SPAT_F_NONE, 0, {pf, ofs}, 1);
				else req(spat_pkg::spat_op_e'(o), la(2, 0, 9'(g), ofs), 0,
					spat_pkg::SPAT_F_PROT, 32'(o), 0, 1);
			end
		end
		req(spat_pkg::SPAT_OP_READ, la(2, 0, 2, 0), 0, spat_pkg::SPAT_F_PROT, 32'h5, 0, 1);
		req(spat_pkg::SPAT_OP_READ, la(2, 0, 3, 0), 0, spat_pkg::SPAT_F_PAGE, 32'h0, 0, 1);
		req(spat_pkg::SPAT_OP_READ, la(2, 0, 5, 0), 0, spat_pkg::SPAT_F_PROT, 32'h0, 0, 1);
		ofs = 10'($urandom);
		req(spat_pkg::SPAT_OP_READ, la(4, 7, 1, ofs), 0, spat_pkg::SPAT_F_NONE, 0, {pf, ofs}, 1);
		req(spat_pkg::SPAT_OP_WRITE, la(4, 7, 1, ofs), 0, spat_pkg::SPAT_F_PROT, 32'h1, 0, 1);
		drain;
		final_report;
	end
endmodule
`default_nettype wire
